// ==== logic/can_ext_id.v ====
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`include "can_ext_id_defs.vh"
// Behaviour
// - Extended identifier has 29 bits, 28 down to 0, over four registers.
// - Identifier bit 28 goes out first, then lower bits descending.
// - Smallest identifier value wins arbitration; higher one backs off.
// - Receive buffer keeps SRR exactly as sampled from the bus.
// - IDE zero means 11-bit format, one means 29-bit; selects sent format.
// - Receive buffer IDE loaded with the received value.
// - Transmit RTR sent in 29-bit format only: zero data frame, one remote frame.
// - Receive buffer RTR loaded from 29-bit frames only; 11-bit frames leave it stale.
module can_ext_id (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output wire [31:0] hrdata_out,
  output wire hreadyout_out,
  output wire hresp_out,
  input wire can_rx_in,
  output wire can_tx_out,
  input wire frame_start_in,
  input wire frame_abort_in,
  input wire bit_strobe_in,
  output wire arb_won_out,
  output wire arb_lost_out,
  output wire tx_active_out
);

  function [7:0] pick_byte;
    input [31:0] v;
    input [1:0] i;
    begin
      case (i)
        2'h0: pick_byte = v[`BYTE0];
        2'h1: pick_byte = v[`BYTE1];
        2'h2: pick_byte = v[`BYTE2];
        default: pick_byte = v[`BYTE3];
      endcase
    end
  endfunction

  function is_ext;
    input [31:0] v;
    begin
      is_ext = v[`VEC_IDE];
    end
  endfunction

  // Bus side state
  reg wr_q, rd_q, rdy_q;
  reg [31:0] a_q;
  reg [31:0] hrdata_q;

  // Identifier storage and control
  reg [31:0] tx_id_q;
  reg [31:0] rx_id_q;
  reg pend_q, won_q, lost_q, rxfull_q, ovr_q, biterr_q, own_q;
  reg [7:0] lostcnt_q;

  // Pin synchroniser
  reg rx_s1_q, rx_s2_q;

  wire tx_busy, tx_won, tx_lost, tx_err, tx_bit;
  wire rx_done;
  wire [31:0] rx_field;

  wire take = hsel_in && htrans_in[`HTRANS_ACT] && hready_in;
  wire mapped = (a_q[31:8] == 24'h0);
  wire [7:0] wofs = a_q[7:0];
  wire [7:0] wb = hwdata_in[7:0];
  wire w_stat = wr_q && mapped && wofs == `OFS_STAT;
  wire w_ctrl = wr_q && mapped && wofs == `OFS_CTRL;

  // Buffer stays with the engine while a request is pending
  wire tx_lock = pend_q || tx_busy;
  wire tx_go = frame_start_in && pend_q && !tx_busy;
  wire [5:0] tx_len = is_ext(tx_id_q) ? `LEN_EXT : `LEN_STD;

  // Own frame is not stored; a lost arbitration makes it foreign
  wire rx_store = rx_done && !(own_q && !tx_lost);

  always @(posedge clk_in) begin
    if (rst_in) begin
      rx_s1_q <= `RECESSIVE;
      rx_s2_q <= `RECESSIVE;
    end else if (ce_in) begin
      rx_s1_q <= can_rx_in;
      rx_s2_q <= rx_s1_q;
    end
  end

  id_tx_shift u_tx (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(tx_go),
    .abort_in(frame_abort_in),
    .field_in(tx_id_q),
    .len_in(tx_len),
    .strobe_in(bit_strobe_in),
    .bus_bit_in(rx_s2_q),
    .tx_out(tx_bit),
    .busy_out(tx_busy),
    .won_out(tx_won),
    .lost_out(tx_lost),
    .err_out(tx_err)
  );

  id_rx_shift u_rx (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(frame_start_in),
    .abort_in(frame_abort_in),
    .strobe_in(bit_strobe_in),
    .bus_bit_in(rx_s2_q),
    .field_out(rx_field),
    .busy_out(),
    .done_out(rx_done)
  );

  // Read decode, also used for unmapped answers
  function [7:0] reg_read;
    input [7:0] ofs;
    input [31:0] txv;
    input [31:0] rxv;
    input [7:0] st;
    input [7:0] cnt;
    begin
      case (ofs)
        `OFS_TX_ID0: reg_read = pick_byte(txv, 2'h0);
        `OFS_TX_ID1: reg_read = pick_byte(txv, 2'h1);
        `OFS_TX_ID2: reg_read = pick_byte(txv, 2'h2);
        `OFS_TX_ID3: reg_read = pick_byte(txv, 2'h3);
        `OFS_RX_ID0: reg_read = pick_byte(rxv, 2'h0);
        `OFS_RX_ID1: reg_read = pick_byte(rxv, 2'h1);
        `OFS_RX_ID2: reg_read = pick_byte(rxv, 2'h2);
        `OFS_RX_ID3: reg_read = pick_byte(rxv, 2'h3);
        `OFS_STAT: reg_read = st;
        `OFS_LOSTCNT: reg_read = cnt;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  reg [7:0] stat;
  always @* begin
    stat = 8'h00;
    stat[`ST_PEND] = pend_q;
    stat[`ST_TXBUSY] = tx_busy;
    stat[`ST_WON] = won_q;
    stat[`ST_LOST] = lost_q;
    stat[`ST_RXFULL] = rxfull_q;
    stat[`ST_OVR] = ovr_q;
    stat[`ST_BITERR] = biterr_q;
    stat[`ST_RXEXT] = is_ext(rx_id_q);
  end

  // Bus phases: writes zero wait, reads one wait state
  always @(posedge clk_in) begin
    if (rst_in) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rdy_q <= 1'b0;
      a_q <= 32'h0;
      hrdata_q <= 32'h0;
    end else if (ce_in) begin
      wr_q <= take && hwrite_in && hsize_in == `HSIZE_WORD;
      if (take) begin
        a_q <= haddr_in;
      end
      if (take && !hwrite_in) begin
        rd_q <= 1'b1;
        rdy_q <= 1'b0;
      end else if (rd_q && !rdy_q) begin
        rdy_q <= 1'b1;
        // Wait state lets a write just before land first
        hrdata_q <= mapped ? {24'h0, reg_read(a_q[7:0], tx_id_q, rx_id_q, stat, lostcnt_q)}
                           : 32'h0;
      end else begin
        rd_q <= 1'b0;
        rdy_q <= 1'b0;
      end
    end
  end

  // Transmit identifier, written byte by byte
  always @(posedge clk_in) begin
    if (rst_in) begin
      tx_id_q <= tx_id_q;
    end else if (ce_in && wr_q && mapped && !tx_lock) begin
      // SRR sent as written; software keeps it recessive
      case (wofs)
        `OFS_TX_ID0: tx_id_q[`BYTE0] <= wb;
        `OFS_TX_ID1: tx_id_q[`BYTE1] <= wb;
        `OFS_TX_ID2: tx_id_q[`BYTE2] <= wb;
        `OFS_TX_ID3: tx_id_q[`BYTE3] <= wb;
        default: tx_id_q <= tx_id_q;
      endcase
    end
  end

  // Receive identifier, loaded only by the engine
  always @(posedge clk_in) begin
    if (rst_in) begin
      rx_id_q <= rx_id_q;
    end else if (ce_in && rx_store && !rxfull_q) begin
      // Standard frames leave the low bytes stale
      rx_id_q <= rx_field;
    end
  end

  // Request, flags and counter; hardware set beats software clear, and won or error clearing the request beats a software request
  always @(posedge clk_in) begin
    if (rst_in) begin
      pend_q <= 1'b0;
      won_q <= 1'b0;
      lost_q <= 1'b0;
      rxfull_q <= 1'b0;
      ovr_q <= 1'b0;
      biterr_q <= 1'b0;
      own_q <= 1'b0;
      lostcnt_q <= 8'h00;
    end else if (ce_in) begin
      if (tx_won || tx_err) begin
        pend_q <= 1'b0;
      end else if (w_ctrl && wb[`CTRL_REQ]) begin
        pend_q <= 1'b1;
      end else if (w_ctrl && wb[`CTRL_CANCEL] && !tx_busy) begin
        pend_q <= 1'b0;
      end

      // Losing arbitration hands the frame to the other node
      if (tx_go) begin
        own_q <= 1'b1;
      end else if (frame_abort_in || frame_start_in || rx_done || tx_lost) begin
        own_q <= 1'b0;
      end

      if (tx_won) begin
        won_q <= 1'b1;
      end else if (w_stat && wb[`ST_WON]) begin
        won_q <= 1'b0;
      end

      if (tx_lost) begin
        lost_q <= 1'b1;
      end else if (w_stat && wb[`ST_LOST]) begin
        lost_q <= 1'b0;
      end

      if (tx_err) begin
        biterr_q <= 1'b1;
      end else if (w_stat && wb[`ST_BITERR]) begin
        biterr_q <= 1'b0;
      end

      if (rx_store) begin
        rxfull_q <= 1'b1;
      end else if (w_stat && wb[`ST_RXFULL]) begin
        rxfull_q <= 1'b0;
      end

      // Held frame wins; a newer one is dropped and flagged
      if (rx_store && rxfull_q) begin
        ovr_q <= 1'b1;
      end else if (w_stat && wb[`ST_OVR]) begin
        ovr_q <= 1'b0;
      end

      if (tx_lost && lostcnt_q != `LOSTCNT_MAX) begin
        lostcnt_q <= lostcnt_q + 8'h01;
      end else if (wr_q && mapped && wofs == `OFS_LOSTCNT) begin
        lostcnt_q <= 8'h00;
      end
    end
  end

  assign hrdata_out = hrdata_q;
  assign hreadyout_out = !(rd_q && !rdy_q);
  assign hresp_out = 1'b0;
  assign can_tx_out = tx_bit;
  assign arb_won_out = tx_won;
  assign arb_lost_out = tx_lost;
  assign tx_active_out = tx_busy;
endmodule // can_ext_id

// ==== inc/can_ext_id_defs.vh ====
`ifndef CAN_EXT_ID_DEFS_VH
`define CAN_EXT_ID_DEFS_VH

// Register byte addresses
`define OFS_TX_ID0 8'h00
`define OFS_TX_ID1 8'h04
`define OFS_TX_ID2 8'h08
`define OFS_TX_ID3 8'h0C
`define OFS_RX_ID0 8'h10
`define OFS_RX_ID1 8'h14
`define OFS_RX_ID2 8'h18
`define OFS_RX_ID3 8'h1C
`define OFS_CTRL 8'h20
`define OFS_STAT 8'h24
`define OFS_LOSTCNT 8'h28

// Identifier byte lanes inside the 32-bit arbitration vector
`define BYTE0 31:24
`define BYTE1 23:16
`define BYTE2 15:8
`define BYTE3 7:0

// Positions inside the arbitration vector, first bit sent at 31
`define VEC_MSB 31
`define VEC_SRR 20
`define VEC_IDE 19
`define VEC_RTR 0
`define POS_START 5'h1F
`define POS_LAST 5'h00

// Arbitration field lengths in bits
`define LEN_STD 6'h0D
`define LEN_EXT 6'h20
`define LEN_ONE 6'h01

// Control bits
`define CTRL_REQ 0
`define CTRL_CANCEL 1

// Status bits
`define ST_PEND 0
`define ST_TXBUSY 1
`define ST_WON 2
`define ST_LOST 3
`define ST_RXFULL 4
`define ST_OVR 5
`define ST_BITERR 6
`define ST_RXEXT 7

`define RECESSIVE 1'b1
`define DOMINANT 1'b0
`define HSIZE_WORD 3'h2
`define HTRANS_ACT 1
`define LOSTCNT_MAX 8'hFF

`endif

// ==== logic/id_tx_shift.v ====
`timescale 1ns/1ns
`include "can_ext_id_defs.vh"
module id_tx_shift (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire start_in,
  input wire abort_in,
  input wire [31:0] field_in,
  input wire [5:0] len_in,
  input wire strobe_in,
  input wire bus_bit_in,
  output wire tx_out,
  output wire busy_out,
  output wire won_out,
  output wire lost_out,
  output wire err_out
);
  reg [31:0] sh_q;
  reg [5:0] cnt_q;
  reg busy_q, tx_q, won_q, lost_q, err_q;

  always @(posedge clk_in) begin
    if (rst_in) begin
      sh_q <= 32'h0;
      cnt_q <= 6'h0;
      busy_q <= 1'b0;
      tx_q <= `RECESSIVE;
      won_q <= 1'b0;
      lost_q <= 1'b0;
      err_q <= 1'b0;
    end else if (ce_in) begin
      won_q <= 1'b0;
      lost_q <= 1'b0;
      err_q <= 1'b0;
      if (abort_in) begin
        busy_q <= 1'b0;
        tx_q <= `RECESSIVE;
      end else if (start_in) begin
        tx_q <= field_in[`VEC_MSB];
        sh_q <= {field_in[30:0], 1'b0};
        cnt_q <= len_in;
        busy_q <= 1'b1;
      end else if (busy_q && strobe_in) begin
        if (tx_q == `RECESSIVE && bus_bit_in == `DOMINANT) begin
          // Lower identifier on the bus wins; back off at once
          busy_q <= 1'b0;
          tx_q <= `RECESSIVE;
          lost_q <= 1'b1;
        end else if (tx_q == `DOMINANT && bus_bit_in == `RECESSIVE) begin
          busy_q <= 1'b0;
          tx_q <= `RECESSIVE;
          err_q <= 1'b1;
        end else if (cnt_q == `LEN_ONE) begin
          busy_q <= 1'b0;
          tx_q <= `RECESSIVE;
          won_q <= 1'b1;
        end else begin
          tx_q <= sh_q[`VEC_MSB];
          sh_q <= {sh_q[30:0], 1'b0};
          cnt_q <= cnt_q - `LEN_ONE;
        end
      end
    end
  end

  assign tx_out = tx_q;
  assign busy_out = busy_q;
  assign won_out = won_q;
  assign lost_out = lost_q;
  assign err_out = err_q;
endmodule // id_tx_shift

// ==== logic/id_rx_shift.v ====
`timescale 1ns/1ns
`include "can_ext_id_defs.vh"
module id_rx_shift (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire start_in,
  input wire abort_in,
  input wire strobe_in,
  input wire bus_bit_in,
  output wire [31:0] field_out,
  output wire busy_out,
  output wire done_out
);
  reg [31:0] f_q;
  reg [4:0] pos_q;
  reg busy_q, done_q;

  always @(posedge clk_in) begin
    if (rst_in) begin
      f_q <= 32'h0;
      pos_q <= `POS_START;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce_in) begin
      done_q <= 1'b0;
      if (abort_in) begin
        busy_q <= 1'b0;
      end else if (start_in) begin
        pos_q <= `POS_START;
        busy_q <= 1'b1;
      end else if (busy_q && strobe_in) begin
        // Every bit, SRR/IDE/RTR included, kept as sampled
        f_q[pos_q] <= bus_bit_in;
        if ((pos_q == `VEC_IDE && bus_bit_in == 1'b0) || pos_q == `POS_LAST) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          pos_q <= pos_q - 5'h01;
        end
      end
    end
  end

  assign field_out = f_q;
  assign busy_out = busy_q;
  assign done_out = done_q;
endmodule // id_rx_shift

// ==== verif/can_ext_id_monitor.sv ====
`timescale 1ns/1ns
module can_ext_id_monitor (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire hsel_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire hready_in,
  input wire [31:0] hrdata_out,
  input wire hreadyout_out,
  input wire hresp_out,
  input wire can_rx_in,
  input wire can_tx_out,
  input wire frame_start_in,
  input wire bit_strobe_in,
  input wire arb_won_out,
  input wire arb_lost_out,
  input wire tx_active_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  wire take = hsel_in & htrans_in[1] & hready_in & ce_in;
  a_resp_okay: assert property (hresp_out == 1'b0)
    else $error("bad response");
  a_rdata_upper: assert property (hrdata_out[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_read_wait: assert property (take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read data phase timing");
  a_write_ready: assert property (take && hwrite_in |=> hreadyout_out)
    else $error("write data phase stalled");
  a_tx_cause: assert property ($changed(can_tx_out) |->
    $past(bit_strobe_in) || $past(bit_strobe_in, 2) || $past(frame_start_in))
    else $error("tx bit changed without strobe");
  a_lost_cause: assert property (bit_strobe_in && tx_active_out && can_tx_out && !can_rx_in
    |-> ##[1:2] arb_lost_out)
    else $error("lost arbitration not flagged");
  a_won_strobe: assert property (arb_won_out |->
    $past(bit_strobe_in) || $past(bit_strobe_in, 2))
    else $error("won without strobe");
  a_won_pulse: assert property (arb_won_out |=> !arb_won_out && !arb_lost_out)
    else $error("won not a pulse");
  cover property (take && !hwrite_in);
  cover property (arb_won_out);
  cover property (arb_lost_out);
endmodule // can_ext_id_monitor

bind can_ext_id can_ext_id_monitor can_ext_id_monitor_i (.clk_in, .rst_in, .ce_in,
  .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
  .can_rx_in, .can_tx_out, .frame_start_in, .bit_strobe_in, .arb_won_out, .arb_lost_out,
  .tx_active_out);

// ==== verif/can_node_model.sv ====
`timescale 1ns/1ns
module can_node_model (
  input wire clk_in,
  input wire can_tx_in,
  output wire can_rx_out,
  output logic frame_start_out,
  output logic bit_strobe_out
);
  logic node_bit = 1'b1;
  logic [31:0] seen_q = 32'h0;
  initial begin
    frame_start_out = 1'b0;
    bit_strobe_out = 1'b0;
  end
  // Wired-AND: dominant wins, released bus rests recessive
  assign can_rx_out = can_tx_in & node_bit;
  // Gap paces the bits; strobes never leave the frame
  task automatic send(input logic [31:0] b, input int n, input int gap);
    @(posedge clk_in);
    frame_start_out <= 1'b1;
    @(posedge clk_in);
    frame_start_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      node_bit <= b[31 - i];
      repeat (gap) @(posedge clk_in);
      seen_q[31 - i] <= can_rx_out;
      bit_strobe_out <= 1'b1;
      @(posedge clk_in);
      bit_strobe_out <= 1'b0;
    end
    node_bit <= 1'b1;
  endtask
endmodule // can_node_model

// ==== verif/can_ext_id_tb.sv ====
`timescale 1ns/1ns
`include "can_ext_id_defs.vh"
module can_ext_id_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h0;
  logic [31:0] hwdata_in = 32'h0;
  wire [31:0] hrdata_out;
  wire hreadyout_out, hresp_out, can_rx_in, can_tx_out, frame_start_in, bit_strobe_in;
  wire arb_won_out, arb_lost_out, tx_active_out;
  int failures = 0, n_checks = 0, n_won = 0, n_lost = 0, cyc = 0;
  logic [31:0] v, lo, sv, rd_v;
  always #5 clk_in = ~clk_in;
  can_ext_id can_ext_id_i (.clk_in, .rst_in, .ce_in(1'b1), .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hrdata_out,
    .hreadyout_out, .hresp_out, .can_rx_in, .can_tx_out, .frame_start_in,
    .frame_abort_in(1'b0), .bit_strobe_in, .arb_won_out, .arb_lost_out, .tx_active_out);
  can_node_model can_node_model_i (.clk_in, .can_tx_in(can_tx_out), .can_rx_out(can_rx_in),
    .frame_start_out(frame_start_in), .bit_strobe_out(bit_strobe_in));
  task final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (arb_won_out === 1'b1) n_won++;
    if (arb_lost_out === 1'b1) n_lost++;
    if (cyc == 8000) begin
      failures++;
      final_report;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, a};
    htrans_in <= 2'h2;
    hwrite_in <= w;
    hsize_in <= `HSIZE_WORD;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd_v = hrdata_out;
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, {24'h0, e}, rd_v);
  endtask
  task load(input logic [31:0] x);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'(4 * i), {24'h0, x[31 - 8 * i -: 8]});
      rdc("tx_id", 8'(4 * i), x[31 - 8 * i -: 8]);
    end
    xfer(1'b1, `OFS_CTRL, 32'h1);
  endtask
  function logic [31:0] pack(input logic [28:0] id, input logic s, e, r);
    return {id[28:18], s, e, id[17:0], r};
  endfunction
  task frame(input logic [31:0] b, input int n, input int gap);
    can_node_model_i.send(b, n, gap);
    repeat (3) @(posedge clk_in);
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    rdc("unmapped", 8'h30, 8'h00);
    v = pack(29'h0ABCDEF1, 1'b1, 1'b1, 1'b0);
    load(v);
    frame(32'hFFFFFFFF, 32, 3);
    chk("ext_bits", v, can_node_model_i.seen_q);
    chk("won_ext", 32'h1, n_won);
    v = {11'h5A3, 2'b10, 19'h0};
    load(v);
    frame(32'hFFFFFFFF, 13, 3);
    chk("std_bits", {19'h0, v[31:19]}, {19'h0, can_node_model_i.seen_q[31:19]});
    chk("won_std", 32'h2, n_won);
    xfer(1'b1, `OFS_STAT, 32'hFF);
    load(pack(29'h10000000, 1'b1, 1'b1, 1'b0));
    lo = pack(29'h0F0F0F0F, 1'b0, 1'b1, 1'b1);
    frame(lo, 32, 9);
    chk("lost", 32'h1, n_lost);
    for (int i = 0; i < 4; i++) rdc("rx_id", 8'(16 + 4 * i), lo[31 - 8 * i -: 8]);
    rdc("stat_ext", `OFS_STAT, 8'h99);
    rdc("lostcnt", `OFS_LOSTCNT, 8'h01);
    xfer(1'b1, 8'h10, 32'h0);
    rdc("rx_ro", 8'h10, lo[31:24]);
    xfer(1'b1, `OFS_CTRL, 32'h2);
    xfer(1'b1, `OFS_STAT, 32'hFF);
    sv = {11'h2C7, 2'b10, 19'h7FFFF};
    frame(sv, 13, 3);
    rdc("rx_std0", 8'h10, sv[31:24]);
    rdc("rx_std1", 8'h14, {sv[23:19], lo[18:16]});
    rdc("stat_std", `OFS_STAT, 8'h10);
    chk("won_end", 32'h2, n_won);
    final_report;
  end
endmodule // can_ext_id_tb
